// ---- rtl/mid_demag_window.v ----
// blanking window down-counter after each commutation, held at zero while bypass is set
`timescale 1ns/100ps
`include "mid_map.vh"
module mid_demag_window
#(
   parameter CLK_MHZ = 40,
   parameter CW      = 16
)
(
   ref_clk,
   resetn,
   clk_en,
   start,
   bypass,
   win_len,
   active
);
   input  wire          ref_clk;
   input  wire          resetn;
   input  wire          clk_en;
   input  wire          start;
   input  wire          bypass;
   input  wire [3:0]    win_len;
   output wire          active;

   reg  [CW-1:0] cnt_reg;
   reg  [CW-1:0] load_val;
   integer       us_val;
   integer       cyc_val;

   // window time in microseconds scaled to clock cycles
   always @*
   begin
      us_val = 0;
      cyc_val = 0;
      if (win_len[`MID_WIN_MSB] == 1'b0)
         us_val = (win_len + `MID_WIN_CODE_ONE) * `MID_WIN_STEP_US;
      else
         us_val = `MID_WIN_LONG_BASE_US
                  + (win_len - `MID_WIN_LONG_CODE) * `MID_WIN_LONG_STEP_US;
      cyc_val = us_val * CLK_MHZ;
      load_val = cyc_val[CW-1:0];
   end

   always @(posedge ref_clk)
   begin
      if (!resetn)
         cnt_reg <= {CW{1'b0}};
      else if (clk_en)
      begin
         if (start && !bypass)
            cnt_reg <= load_val;
         else if (bypass)
            cnt_reg <= {CW{1'b0}};
         else if (cnt_reg != {CW{1'b0}})
            cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign active = (cnt_reg != {CW{1'b0}});
endmodule // mid_demag_window

// ---- rtl/mid_input_detect.v ----
// motor input detection front end with demag window and event filter
`timescale 1ns/100ps
`include "mid_map.vh"
module mid_input_detect
#(
   parameter CLK_MHZ = 40
)
(
   ref_clk,
   resetn,
   clk_en,
   motor_input_a,
   motor_input_b,
   motor_input_c,
   comp_out,
   input_select,
   sensor_type_select,
   sensor_mode_bit,
   ctrl_clk_enable,
   ctrl_dac_enable,
   ref_level_select,
   voltage_mode,
   window_prescale,
   window_tick,
   pwm_u_tick,
   demag_sample_tick,
   autoswitch_hard,
   compare_polarity_bit,
   zero_vs_demag_edge_bit,
   demag_window_len,
   demag_count_limit,
   hw_commutation,
   sw_commutation,
   sim_demag,
   comp_power_on,
   comp_ref_ext,
   comp_ref_level,
   comp_in_sel,
   digital_in,
   hall_state,
   speed_sensor_mode,
   demag_flag,
   zero_cross_flag,
   demag_window_busy
);
   input  wire       ref_clk;
   input  wire       resetn;
   input  wire       clk_en;
   input  wire       motor_input_a;
   input  wire       motor_input_b;
   input  wire       motor_input_c;
   input  wire       comp_out;
   input  wire [1:0] input_select;
   input  wire [1:0] sensor_type_select;
   input  wire       sensor_mode_bit;
   input  wire       ctrl_clk_enable;
   input  wire       ctrl_dac_enable;
   input  wire [2:0] ref_level_select;
   input  wire       voltage_mode;
   input  wire [3:0] window_prescale;
   input  wire       window_tick;
   input  wire       pwm_u_tick;
   input  wire       demag_sample_tick;
   input  wire       autoswitch_hard;
   input  wire       compare_polarity_bit;
   input  wire       zero_vs_demag_edge_bit;
   input  wire [3:0] demag_window_len;
   input  wire [3:0] demag_count_limit;
   input  wire       hw_commutation;
   input  wire       sw_commutation;
   input  wire       sim_demag;
   output reg        comp_power_on;
   output reg        comp_ref_ext;
   output reg  [2:0] comp_ref_level;
   output reg  [1:0] comp_in_sel;
   output reg        digital_in;
   output reg  [2:0] hall_state;
   output reg        speed_sensor_mode;
   output reg        demag_flag;
   output reg        zero_cross_flag;
   output reg        demag_window_busy;

   localparam ST_WAIT_D = 1'b0;
   localparam ST_WAIT_Z = 1'b1;

   reg        state_reg;
   reg        state_next;
   reg        sample_prev_reg;
   reg  [4:0] demag_cnt_reg;
   reg        mux_bit;
   wire       commutation;
   wire       win_active;
   wire       speed_mode;
   wire       z_tick;
   wire       d_tick;
   wire       edge_rise;
   wire       edge_fall;
   wire       d_edge;
   wire       z_edge;
   wire [4:0] limit_eff;
   wire       d_hw_done;

   assign commutation = hw_commutation | sw_commutation;
   assign speed_mode  = (sensor_type_select != `MID_TES_POS_SENSOR);

   // input multiplexer
   always @*
   begin
      case (input_select)
         `MID_IS_A: mux_bit = motor_input_a;
         `MID_IS_B: mux_bit = motor_input_b;
         `MID_IS_C: mux_bit = motor_input_c;
         default:   mux_bit = 1'b0;
      endcase
   end

   assign z_tick = voltage_mode ? pwm_u_tick : window_tick;
   assign d_tick = demag_sample_tick;

   // comparator output or digital input, sampled
   wire sample_now = speed_mode ? mux_bit : comp_out;
   assign edge_rise = sample_now & ~sample_prev_reg;
   assign edge_fall = ~sample_now & sample_prev_reg;
   // demag edge opposite to zero crossing unless same-edge bit set
   assign z_edge = compare_polarity_bit ? edge_rise : edge_fall;
   assign d_edge = (zero_vs_demag_edge_bit ^ compare_polarity_bit) ? edge_fall
                                                                   : edge_rise;
   assign limit_eff = sim_demag ? `MID_LIMIT_ONE
                                : ({1'b0, demag_count_limit} + `MID_LIMIT_ONE);
   assign d_hw_done = sensor_mode_bit ? 1'b1
                                      : ((demag_cnt_reg + `MID_CNT_ONE) >= limit_eff);

   mid_demag_window #(
      .CLK_MHZ (CLK_MHZ),
      .CW      (16)
   ) u_win (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .start   (commutation),
      .bypass  (sensor_mode_bit),
      .win_len (demag_window_len),
      .active  (win_active)
   );

   // event order state
   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_WAIT_D:
            if (!speed_mode && !win_active && ((d_tick && d_edge && d_hw_done) || sim_demag))
               state_next = ST_WAIT_Z;
         ST_WAIT_Z:
            if (z_tick && z_edge && !commutation)
               state_next = ST_WAIT_D;
         default:
            state_next = ST_WAIT_D;
      endcase
      if (commutation && autoswitch_hard)
         state_next = ST_WAIT_D;
   end

   always @(posedge ref_clk)
   begin
      if (!resetn)
      begin
         state_reg         <= ST_WAIT_D;
         sample_prev_reg   <= 1'b0;
         demag_cnt_reg     <= `MID_CNT_ZERO;
         comp_power_on     <= 1'b0;
         comp_ref_ext      <= 1'b0;
         comp_ref_level    <= 3'h0;
         comp_in_sel       <= 2'h0;
         digital_in        <= 1'b0;
         hall_state        <= 3'h0;
         speed_sensor_mode <= 1'b0;
         demag_flag        <= 1'b0;
         zero_cross_flag   <= 1'b0;
         demag_window_busy <= 1'b0;
      end
      else if (clk_en)
      begin
         state_reg         <= state_next;
         if (d_tick || z_tick)
            sample_prev_reg <= sample_now;
         comp_power_on     <= (ctrl_clk_enable | ctrl_dac_enable) & ~speed_mode;
         comp_ref_ext      <= (ref_level_select == `MID_VR_EXT);
         comp_ref_level    <= ref_level_select;
         comp_in_sel       <= input_select;
         digital_in        <= speed_mode ? mux_bit : 1'b0;
         hall_state        <= (sensor_mode_bit && !speed_mode) ?
                              {motor_input_c, motor_input_b, motor_input_a} : 3'h0;
         speed_sensor_mode <= speed_mode;
         demag_window_busy <= win_active;
         demag_flag        <= 1'b0;
         zero_cross_flag   <= 1'b0;
         if (commutation || win_active)
            demag_cnt_reg <= `MID_CNT_ZERO;
         else if (state_reg == ST_WAIT_D && !speed_mode)
         begin
            if (sim_demag)
            begin
               demag_cnt_reg <= `MID_CNT_ZERO;
               demag_flag    <= 1'b1;
            end
            else if (d_tick)
            begin
               if (d_edge && d_hw_done)
               begin
                  demag_cnt_reg <= `MID_CNT_ZERO;
                  demag_flag    <= 1'b1;
               end
               else if (d_edge)
                  demag_cnt_reg <= demag_cnt_reg + `MID_CNT_ONE;
               else
                  demag_cnt_reg <= `MID_CNT_ZERO;
            end
         end
         if (state_reg == ST_WAIT_Z && z_tick && z_edge && !commutation)
            zero_cross_flag <= 1'b1;
      end
   end
endmodule // mid_input_detect

// ---- rtl/mid_map.vh ----
// constants for the motor input detection front end
`ifndef MID_MAP_VH
`define MID_MAP_VH
`define MID_TES_POS_SENSOR   2'h0
`define MID_IS_A             2'h0
`define MID_IS_B             2'h1
`define MID_IS_C             2'h2
`define MID_VR_EXT           3'h7
`define MID_REF_PERIPH_MHZ   4
`define MID_WIN_STEP_US      5
`define MID_WIN_LONG_BASE_US 60
`define MID_WIN_LONG_STEP_US 20
`define MID_WIN_CODE_ONE     1
`define MID_WIN_LONG_CODE    8
`define MID_WIN_MSB          3
`define MID_WIN_ZERO         4'h0
`define MID_CNT_ZERO         5'h00
`define MID_CNT_ONE          5'h01
`define MID_LIMIT_ONE        5'h01
`endif

// ---- verification/mid_input_detect_asserts.sv ----
// assertions for the motor input detection front end
`timescale 1ns/100ps
module mid_input_detect_chk(
   input wire       ref_clk, resetn, clk_en, motor_input_a, motor_input_b, motor_input_c,
   input wire [1:0] input_select, sensor_type_select, comp_in_sel,
   input wire [2:0] ref_level_select, hall_state,
   input wire       sensor_mode_bit, ctrl_clk_enable, ctrl_dac_enable, hw_commutation,
   input wire       sw_commutation, comp_power_on, comp_ref_ext, digital_in,
   input wire       speed_sensor_mode, demag_flag, zero_cross_flag, demag_window_busy);
   reg  live;
   wire mux = input_select == 2'h0 ? motor_input_a : input_select == 2'h1 ? motor_input_b :
              input_select == 2'h2 ? motor_input_c : 1'b0;
   always @(posedge ref_clk) live <= resetn & clk_en;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   ref_ext_a: assert property (live |-> comp_ref_ext == ($past(ref_level_select) == 3'h7))
      else $error("reference select wrong");
   power_on_a: assert property (live |-> comp_power_on ==
      ($past(ctrl_clk_enable | ctrl_dac_enable) && $past(sensor_type_select) == 2'h0))
      else $error("comparator power wrong");
   speed_mode_a: assert property (live |->
      speed_sensor_mode == ($past(sensor_type_select) != 2'h0))
      else $error("speed mode wrong");
   in_sel_a: assert property (live |-> comp_in_sel == $past(input_select))
      else $error("input select wrong");
   hall_pos_a: assert property (live |-> hall_state ==
      ($past(sensor_mode_bit && sensor_type_select == 2'h0) ?
      $past({motor_input_c, motor_input_b, motor_input_a}) : 3'h0))
      else $error("hall state wrong");
   digital_a: assert property (live && $past(sensor_type_select) != 2'h0 |->
      digital_in == $past(mux))
      else $error("digital input wrong");
   busy_start_a: assert property (clk_en && !sensor_mode_bit && (hw_commutation | sw_commutation)
      |-> ##2 demag_window_busy)
      else $error("window not started");
   no_window_a: assert property (!demag_window_busy && hw_commutation && sensor_mode_bit
      ##1 sensor_mode_bit |=> !demag_window_busy)
      else $error("window in sensor mode");
   blank_flag_a: assert property (demag_window_busy ##1 demag_window_busy |-> !demag_flag)
      else $error("demag flag inside window");
   cover property (demag_flag);
   cover property (zero_cross_flag);
   cover property (digital_in);
endmodule // mid_input_detect_chk
bind mid_input_detect mid_input_detect_chk mid_input_detect_chk_i (.*);

// ---- verification/mid_phase_model.sv ----
// far side model: motor phase levels and comparator result
`timescale 1ns/100ps
module mid_phase_model(
   input wire       ref_clk, enc_mode,
   input wire [3:0] tgt,
   output reg       motor_input_a = 0, motor_input_b = 0, motor_input_c = 0, comp_out = 0);
   always @(posedge ref_clk)
   begin
      {comp_out, motor_input_b, motor_input_a} <= {tgt[3], tgt[1:0]};
      motor_input_c <= enc_mode ? 1'b0 : tgt[2];
   end
endmodule // mid_phase_model

// ---- verification/test_motor_input_detection_demag_filter.sv ----
// self-checking bench for the motor input detection front end
`timescale 1ns/100ps
module test_motor_input_detection_demag_filter;
   reg        ref_clk = 0, resetn = 0, clk_en = 1, voltage_mode = 0, autoswitch_hard = 1;
   reg  [1:0] input_select = 0, sensor_type_select = 0;
   reg  [2:0] ref_level_select = 0;
   reg  [3:0] window_prescale = 0, demag_window_len = 4'hf, demag_count_limit = 0, tgt = 0;
   reg        sensor_mode_bit = 0, ctrl_clk_enable = 0, ctrl_dac_enable = 0, sim_demag = 0;
   reg        window_tick = 0, pwm_u_tick = 0, demag_sample_tick = 0, hw_commutation = 0;
   reg        compare_polarity_bit = 0, zero_vs_demag_edge_bit = 0, sw_commutation = 0;
   wire       motor_input_a, motor_input_b, motor_input_c, comp_out, comp_power_on;
   wire       comp_ref_ext, digital_in, speed_sensor_mode, demag_flag, zero_cross_flag;
   wire       demag_window_busy;
   wire [2:0] comp_ref_level, hall_state;
   wire [1:0] comp_in_sel;
   integer    mismatches = 0, tests_run = 0;
   logic      f;
   always #12.5 ref_clk = ~ref_clk;
   mid_input_detect #(.CLK_MHZ(1)) mid_input_detect_i (.*);
   mid_phase_model mid_phase_model_i (.*, .enc_mode(sensor_type_select == 2'h3));
   task tick(input integer n);
      repeat (n) @(posedge ref_clk);
      #2;
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task rise(input z, input lvl);
      tgt[3] = !lvl;
      repeat (2)
      begin
         tick(2);
         window_tick = z & !voltage_mode;
         pwm_u_tick = z & voltage_mode;
         demag_sample_tick = !z;
         tick(1);
         window_tick = 0;
         pwm_u_tick = 0;
         demag_sample_tick = 0;
         tgt[3] = lvl;
      end
      f = 0;
      repeat (3)
      begin
         f = f | (z ? zero_cross_flag : demag_flag);
         tick(1);
      end
   endtask
   task comm(input sw);
      hw_commutation = !sw;
      sw_commutation = sw;
      tick(1);
      hw_commutation = 0;
      sw_commutation = 0;
   endtask
   task test_cfg;
      integer i;
      ctrl_clk_enable = 1;
      for (i = 0; i < 8; i++)
      begin
         ref_level_select = i;
         tick(2);
         chk("ref_ext", comp_ref_ext, i == 7);
         chk("ref_level", comp_ref_level, i[2:0]);
         chk("power", comp_power_on, ctrl_dac_enable || i < 6);
         if (i == 5) {ctrl_clk_enable, ctrl_dac_enable} = 2'h1;
         if (i == 6) ctrl_dac_enable = 0;
      end
      clk_en = 0;
      ref_level_select = 3'h2;
      tick(2);
      chk("frozen", comp_ref_level, 3'h7);
      clk_en = 1;
      $display("test cfg done");
   endtask
   task test_inputs;
      integer i;
      ctrl_clk_enable = 1;
      sensor_type_select = 1;
      for (i = 0; i < 4; i++)
      begin
         input_select = i;
         tgt = 4'h1 << i;
         tick(3);
         chk("digital", digital_in, i < 3);
         chk("in_sel", comp_in_sel, i[1:0]);
         chk("speed", speed_sensor_mode, 1);
         chk("power", comp_power_on, 0);
      end
      sensor_type_select = 3;
      input_select = 2;
      tgt = 4'h4;
      tick(3);
      chk("encoder c", digital_in, 0);
      chk("speed", speed_sensor_mode, 1);
      sensor_type_select = 0;
      sensor_mode_bit = 1;
      tgt = 4'h5;
      tick(3);
      chk("hall", hall_state, 3'h5);
      chk("speed", speed_sensor_mode, 0);
      sensor_mode_bit = 0;
      $display("test inputs done");
   endtask
   task test_window(input [3:0] code, input sw);
      integer n, len;
      len = code < 8 ? (code + 1) * 5 : 60 + (code - 8) * 20;
      demag_window_len = code;
      comm(sw);
      for (n = 0; demag_window_busy !== 1'b1 && n < 4; n++) tick(1);
      for (n = 0; demag_window_busy === 1'b1 && n < 300; n++) tick(1);
      chk("window", n[7:0], len[7:0]);
      if (n == 0 || n == 300) stop_test;
      $display("test window %h done", code);
   endtask
   task test_demag;
      compare_polarity_bit = 1;
      comm(0);
      tick(4);
      rise(0, 0);
      chk("blanked", f, 0);
      tick(200);
      rise(1, 1);
      chk("z early", f, 0);
      rise(0, 0);
      chk("demag", f, 1);
      rise(1, 1);
      chk("zero", f, 1);
      voltage_mode = 1;
      rise(0, 0);
      chk("demag", f, 1);
      rise(1, 1);
      chk("zero pwm", f, 1);
      voltage_mode = 0;
      $display("test demag done");
   endtask
   task test_hall;
      sensor_mode_bit = 1;
      demag_count_limit = 4'h3;
      comm(0);
      tick(1);
      chk("busy", demag_window_busy, 0);
      rise(0, 0);
      chk("demag", f, 1);
      sensor_mode_bit = 0;
      demag_window_len = 4'h0;
      comm(1);
      tick(8);
      sim_demag = 1;
      tick(1);
      sim_demag = 0;
      chk("sim", demag_flag, 1);
      tick(1);
      chk("sim", demag_flag | zero_cross_flag, 0);
      $display("test hall done");
   endtask
   initial
   begin
      tick(12);
      resetn = 1;
      tick(1);
      test_cfg;
      test_inputs;
      test_window(4'h0, 0);
      test_window(4'h7, 1);
      test_window(4'h8, 0);
      test_window(4'hf, 1);
      test_demag;
      test_hall;
      stop_test;
   end
endmodule // test_motor_input_detection_demag_filter
